// [rtl/vetr_defs.vh]
`ifndef VETR_DEFS_VH
`define VETR_DEFS_VH

// register addresses on the serial control port
`define VETR_ADDR_FREQ0 5'h09
`define VETR_ADDR_FREQ1 5'h0A
`define VETR_ADDR_FREQ2 5'h0B
`define VETR_ADDR_FREQ3 5'h0C
`define VETR_ADDR_TIMING 5'h08
`define VETR_ADDR_PHASE 5'h0D
`define VETR_ADDR_CAP_EVEN0 5'h0E
`define VETR_ADDR_CAP_EVEN1 5'h0F
`define VETR_ADDR_CAP_ODD0 5'h10
`define VETR_ADDR_CAP_ODD1 5'h11
`define VETR_ADDR_LINE0 5'h12
`define VETR_ADDR_LINE1 5'h13
`define VETR_ADDR_LINE2 5'h14
`define VETR_ADDR_LINE3 5'h15
`define VETR_ADDR_CM_CTRL 5'h16
`define VETR_ADDR_CM_MID 5'h17
`define VETR_ADDR_CM_LOW 5'h18
`define VETR_ADDR_TEXT_EDGES 5'h19

`define VETR_RESET_BYTE 8'h00
`define VETR_CRC_PRESET 6'h3F

// timing adjust fields
`define VETR_TA_HWIDTH 1:0
`define VETR_TA_HVDELAY 3:2
`define VETR_TA_MODE_FIELD 5:4
`define VETR_TA_PIXEL 7:6

// copy management control fields
`define VETR_CM_TAIL 3:0
`define VETR_CM_AUTO_CRC 4
`define VETR_CM_ODD_EN 5
`define VETR_CM_EVEN_EN 6
`define VETR_CM_WIDE_EN 7

// shared copy/wide data field of the mid register, and the CRC input length
`define VETR_CM_SHARED 5:0
`define VETR_CRC_DATA_BITS 14

// text request edge fields
`define VETR_TE_RISE 7:4
`define VETR_TE_FALL 3:0
`define VETR_NIBBLE_ZERO 4'h0

// timing modes
`define VETR_MODE_ONE 2'h1
`define VETR_MODE_TWO 2'h2

`endif

// [rtl/vetr_regs.v]
// What this block does
// - read/write timing adjust register at 08h
// - bits 1:0 give line sync width
// - bits 3:2 shift line sync against field sync
// - master mode 1: bits 5:4 shift line sync
// - master mode 2: bits 5:4 give frame sync width
// - bits 7:6 shift line sync against pixels
// - four bytes form subcarrier frequency word
// - phase register, 1.41 degrees per step
// - even field caption low and high bytes
// - odd field caption low and high bytes
// - NTSC: set line bit removes pedestal
// - PAL: set line bit enables teletext
// - upper nibble places text request rise
// - lower nibble places text request fall
// - zero fall nibble makes fall track rise
// - control low nibble ends copy stream
// - bit 4 selects computed CRC
// - NTSC: bit 5 enables odd field copy data
// - NTSC: bit 6 enables even field copy data
// - PAL: bit 7 enables wide screen data
// - mid register shared, top bits copy only
// - low register shared copy/wide data
// - CRC x^6+x+1, preset all ones
`timescale 1ns/1ps
`include "vetr_defs.vh"

module vetr_regs (
  input wire clock,
  input wire srst,
  input wire wr_en,
  input wire rd_en,
  input wire [4:0] addr,
  input wire [7:0] wr_data,
  input wire pal_mode,
  input wire master_mode,
  input wire [1:0] timing_mode,
  input wire rise_move,
  output reg [7:0] rd_data,
  output reg rd_hit,
  output wire [1:0] line_sync_width,
  output wire [1:0] line_to_field_delay,
  output wire [1:0] line_to_field_rise_delay,
  output wire [1:0] frame_sync_width,
  output wire [1:0] line_to_pixel_adjust,
  output wire [31:0] subcarrier_freq_word,
  output wire [7:0] subcarrier_phase,
  output wire [15:0] caption_even_bytes,
  output wire [15:0] caption_odd_bytes,
  output wire [15:0] pedestal_odd_lines,
  output wire [15:0] pedestal_even_lines,
  output wire [15:0] text_odd_lines,
  output wire [15:0] text_even_lines,
  output wire [3:0] text_request_rise,
  output wire [3:0] text_request_fall,
  output wire fall_tracks_rise,
  output wire auto_crc_select,
  output wire odd_field_copy_enable,
  output wire even_field_copy_enable,
  output wire wide_screen_enable,
  output reg [19:0] copy_generation_data,
  output wire [13:0] wide_screen_data
);

  reg [7:0] sync_timing_adjust_reg;
  reg [7:0] subcarrier_freq_words_reg [0:3];
  reg [7:0] subcarrier_phase_reg;
  reg [7:0] caption_even_reg [0:1];
  reg [7:0] caption_odd_reg [0:1];
  reg [7:0] line_enable_reg [0:3];
  reg [7:0] copy_mgmt_control_reg;
  reg [7:0] copy_mgmt_data_mid_reg;
  reg [7:0] copy_mgmt_data_low_reg;
  reg [7:0] text_request_edges_reg;
  reg [5:0] crc_value;
  reg [7:0] rd_next;
  reg rd_hit_next;
  integer i;

  // serial CRC over c0..c13, shifted in lsb first
  function [5:0] vetr_crc6;
    input [13:0] data;
    reg [5:0] c;
    reg fb;
    integer k;
    begin
      c = `VETR_CRC_PRESET;
      for (k = 0; k < `VETR_CRC_DATA_BITS; k = k + 1)
      begin
        fb = c[5] ^ data[k];
        c = {c[4:1], c[0] ^ fb, fb};
      end
      vetr_crc6 = c;
    end
  endfunction

  always @(posedge clock)
  begin
    if (srst)
    begin
      sync_timing_adjust_reg <= `VETR_RESET_BYTE;
      subcarrier_phase_reg <= `VETR_RESET_BYTE;
      copy_mgmt_control_reg <= `VETR_RESET_BYTE;
      copy_mgmt_data_mid_reg <= `VETR_RESET_BYTE;
      copy_mgmt_data_low_reg <= `VETR_RESET_BYTE;
      text_request_edges_reg <= `VETR_RESET_BYTE;
      for (i = 0; i < 4; i = i + 1)
      begin
        subcarrier_freq_words_reg[i] <= `VETR_RESET_BYTE;
        line_enable_reg[i] <= `VETR_RESET_BYTE;
      end
      for (i = 0; i < 2; i = i + 1)
      begin
        caption_even_reg[i] <= `VETR_RESET_BYTE;
        caption_odd_reg[i] <= `VETR_RESET_BYTE;
      end
    end
    else if (wr_en)
    begin
      case (addr)
        `VETR_ADDR_TIMING: sync_timing_adjust_reg <= wr_data;
        `VETR_ADDR_FREQ0: subcarrier_freq_words_reg[0] <= wr_data;
        `VETR_ADDR_FREQ1: subcarrier_freq_words_reg[1] <= wr_data;
        `VETR_ADDR_FREQ2: subcarrier_freq_words_reg[2] <= wr_data;
        `VETR_ADDR_FREQ3: subcarrier_freq_words_reg[3] <= wr_data;
        `VETR_ADDR_PHASE: subcarrier_phase_reg <= wr_data;
        `VETR_ADDR_CAP_EVEN0: caption_even_reg[0] <= wr_data;
        `VETR_ADDR_CAP_EVEN1: caption_even_reg[1] <= wr_data;
        `VETR_ADDR_CAP_ODD0: caption_odd_reg[0] <= wr_data;
        `VETR_ADDR_CAP_ODD1: caption_odd_reg[1] <= wr_data;
        `VETR_ADDR_LINE0: line_enable_reg[0] <= wr_data;
        `VETR_ADDR_LINE1: line_enable_reg[1] <= wr_data;
        `VETR_ADDR_LINE2: line_enable_reg[2] <= wr_data;
        `VETR_ADDR_LINE3: line_enable_reg[3] <= wr_data;
        `VETR_ADDR_CM_CTRL: copy_mgmt_control_reg <= wr_data;
        `VETR_ADDR_CM_MID: copy_mgmt_data_mid_reg <= wr_data;
        `VETR_ADDR_CM_LOW: copy_mgmt_data_low_reg <= wr_data;
        `VETR_ADDR_TEXT_EDGES: text_request_edges_reg <= wr_data;
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero with rd_hit low
  always @*
  begin
    rd_next = `VETR_RESET_BYTE;
    rd_hit_next = 1'b1;
    case (addr)
      `VETR_ADDR_TIMING: rd_next = sync_timing_adjust_reg;
      `VETR_ADDR_FREQ0: rd_next = subcarrier_freq_words_reg[0];
      `VETR_ADDR_FREQ1: rd_next = subcarrier_freq_words_reg[1];
      `VETR_ADDR_FREQ2: rd_next = subcarrier_freq_words_reg[2];
      `VETR_ADDR_FREQ3: rd_next = subcarrier_freq_words_reg[3];
      `VETR_ADDR_PHASE: rd_next = subcarrier_phase_reg;
      `VETR_ADDR_CAP_EVEN0: rd_next = caption_even_reg[0];
      `VETR_ADDR_CAP_EVEN1: rd_next = caption_even_reg[1];
      `VETR_ADDR_CAP_ODD0: rd_next = caption_odd_reg[0];
      `VETR_ADDR_CAP_ODD1: rd_next = caption_odd_reg[1];
      `VETR_ADDR_LINE0: rd_next = line_enable_reg[0];
      `VETR_ADDR_LINE1: rd_next = line_enable_reg[1];
      `VETR_ADDR_LINE2: rd_next = line_enable_reg[2];
      `VETR_ADDR_LINE3: rd_next = line_enable_reg[3];
      `VETR_ADDR_CM_CTRL: rd_next = copy_mgmt_control_reg;
      `VETR_ADDR_CM_MID: rd_next = copy_mgmt_data_mid_reg;
      `VETR_ADDR_CM_LOW: rd_next = copy_mgmt_data_low_reg;
      `VETR_ADDR_TEXT_EDGES: rd_next = text_request_edges_reg;
      default: rd_hit_next = 1'b0;
    endcase
  end

  always @(posedge clock)
  begin
    if (srst)
    begin
      rd_data <= `VETR_RESET_BYTE;
      rd_hit <= 1'b0;
    end
    else if (rd_en)
    begin
      rd_data <= rd_next;
      rd_hit <= rd_hit_next;
    end
  end

  assign line_sync_width = sync_timing_adjust_reg[`VETR_TA_HWIDTH];
  assign line_to_field_delay = sync_timing_adjust_reg[`VETR_TA_HVDELAY];
  // the shared field means one of these two reads zero in every mode
  assign line_to_field_rise_delay = (master_mode && timing_mode == `VETR_MODE_ONE) ?
    sync_timing_adjust_reg[`VETR_TA_MODE_FIELD] : 2'h0;
  assign frame_sync_width = (master_mode && timing_mode == `VETR_MODE_TWO) ?
    sync_timing_adjust_reg[`VETR_TA_MODE_FIELD] : 2'h0;
  assign line_to_pixel_adjust = sync_timing_adjust_reg[`VETR_TA_PIXEL];

  // consumer computes f = word * fclk / (2^32-1)
  assign subcarrier_freq_word = {subcarrier_freq_words_reg[3], subcarrier_freq_words_reg[2],
    subcarrier_freq_words_reg[1], subcarrier_freq_words_reg[0]};
  assign subcarrier_phase = subcarrier_phase_reg;
  assign caption_even_bytes = {caption_even_reg[1], caption_even_reg[0]};
  assign caption_odd_bytes = {caption_odd_reg[1], caption_odd_reg[0]};

  assign pedestal_odd_lines = pal_mode ? 16'h0000 : {line_enable_reg[1], line_enable_reg[0]};
  assign pedestal_even_lines = pal_mode ? 16'h0000 : {line_enable_reg[3], line_enable_reg[2]};
  assign text_odd_lines = pal_mode ? {line_enable_reg[1], line_enable_reg[0]} : 16'h0000;
  assign text_even_lines = pal_mode ? {line_enable_reg[3], line_enable_reg[2]} : 16'h0000;

  assign text_request_rise = text_request_edges_reg[`VETR_TE_RISE];
  assign text_request_fall = text_request_edges_reg[`VETR_TE_FALL];
  // waveform generator keeps the edge spacing when rise moves and this is high
  assign fall_tracks_rise = rise_move &&
    (text_request_edges_reg[`VETR_TE_FALL] == `VETR_NIBBLE_ZERO);

  assign auto_crc_select = copy_mgmt_control_reg[`VETR_CM_AUTO_CRC];
  assign odd_field_copy_enable = !pal_mode && copy_mgmt_control_reg[`VETR_CM_ODD_EN];
  assign even_field_copy_enable = !pal_mode && copy_mgmt_control_reg[`VETR_CM_EVEN_EN];
  assign wide_screen_enable = pal_mode && copy_mgmt_control_reg[`VETR_CM_WIDE_EN];

  // c0..c7 from low reg, c8..c15 from mid reg, c16..c19 from control tail; with bit 4 set, c14..c19 are the computed CRC
  always @*
  begin
    crc_value = vetr_crc6({copy_mgmt_data_mid_reg[`VETR_CM_SHARED], copy_mgmt_data_low_reg});
    if (copy_mgmt_control_reg[`VETR_CM_AUTO_CRC])
      copy_generation_data = {crc_value, copy_mgmt_data_mid_reg[`VETR_CM_SHARED], copy_mgmt_data_low_reg};
    else
      copy_generation_data = {copy_mgmt_control_reg[`VETR_CM_TAIL], copy_mgmt_data_mid_reg,
        copy_mgmt_data_low_reg};
  end

  // wide screen uses w0..w7 low reg and w8..w13 mid reg, never the tail
  assign wide_screen_data = {copy_mgmt_data_mid_reg[`VETR_CM_SHARED], copy_mgmt_data_low_reg};

endmodule // vetr_regs

// [verif/vetr_regs_sva.sv]
`timescale 1ns/1ps
module vetr_regs_sva (
  input wire clock,
  input wire srst,
  input wire wr_en,
  input wire rd_en,
  input wire [4:0] addr,
  input wire [7:0] wr_data,
  input wire pal_mode,
  input wire master_mode,
  input wire [1:0] timing_mode,
  input wire rise_move,
  input wire rd_hit,
  input wire [1:0] line_sync_width,
  input wire [1:0] line_to_field_rise_delay,
  input wire [1:0] frame_sync_width,
  input wire [1:0] line_to_pixel_adjust,
  input wire [3:0] text_request_fall,
  input wire fall_tracks_rise,
  input wire odd_field_copy_enable,
  input wire even_field_copy_enable,
  input wire wide_screen_enable
);
  // last cycle's write data, so fields can be sliced without $past on a slice
  logic [7:0] wd_q;
  always @(posedge clock) wd_q <= wr_data;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_tim_wr;
    wr_en && addr == 5'h08;
  endsequence
  AST_RD_HIT: assert property (rd_en |=> rd_hit == ($past(addr) >= 5'h08 && $past(addr) <= 5'h19))
    else $error("read hit flag wrong");
  AST_WIDTH: assert property (s_tim_wr |=> line_sync_width == wd_q[1:0])
    else $error("line sync width not taken");
  AST_MODE1: assert property (s_tim_wr ##1 (master_mode && timing_mode == 2'h1) |-> line_to_field_rise_delay == wd_q[5:4])
    else $error("mode 1 field delay wrong");
  AST_MODE2: assert property (s_tim_wr ##1 (master_mode && timing_mode == 2'h2) |-> frame_sync_width == wd_q[5:4])
    else $error("mode 2 frame width wrong");
  AST_PIXEL: assert property (s_tim_wr |=> line_to_pixel_adjust == wd_q[7:6])
    else $error("pixel adjust not taken");
  AST_TRACK: assert property (rise_move && text_request_fall == 4'h0 |-> fall_tracks_rise)
    else $error("fall edge does not track");
  AST_NTSC_ONLY: assert property (pal_mode |-> !odd_field_copy_enable && !even_field_copy_enable)
    else $error("copy enable active in pal");
  AST_PAL_ONLY: assert property (!pal_mode |-> !wide_screen_enable)
    else $error("wide screen active in ntsc");
endmodule // vetr_regs_sva
bind vetr_regs vetr_regs_sva u_sva (.*);

// [verif/video_encoder_timing_vbi_regs_test.sv]
`timescale 1ns/1ps
module video_encoder_timing_vbi_regs_test;
  reg clock = 1'b0, srst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, pal_mode = 1'b0, master_mode = 1'b1, rise_move = 1'b0;
  reg [1:0] timing_mode = 2'h1;
  reg [4:0] addr = 5'h00;
  reg [7:0] wr_data = 8'h00;
  reg [7:0] sh [8:25];
  reg [13:0] cw;
  reg [5:0] crc;
  wire [7:0] rd_data, subcarrier_phase;
  wire rd_hit, fall_tracks_rise, auto_crc_select, odd_field_copy_enable, even_field_copy_enable, wide_screen_enable;
  wire [1:0] line_sync_width, line_to_field_delay, line_to_field_rise_delay, frame_sync_width, line_to_pixel_adjust;
  wire [31:0] subcarrier_freq_word;
  wire [15:0] caption_even_bytes, caption_odd_bytes, pedestal_odd_lines, pedestal_even_lines, text_odd_lines, text_even_lines;
  wire [3:0] text_request_rise, text_request_fall;
  wire [19:0] copy_generation_data;
  wire [13:0] wide_screen_data;
  integer error_cnt = 0, samples_checked = 0, i, m;
  always #5 clock = ~clock;
  vetr_regs u_dut (.*);
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // strobes are only cleared by the next call, so requests can go back to back
  task drive(input w, input r, input [4:0] a, input [7:0] d);
    begin
      @(posedge clock);
      #1 wr_en = w;
      rd_en = r;
      addr = a;
      wr_data = d;
    end
  endtask
  task rd(input [4:0] a, input [7:0] exp, input hit);
    begin
      drive(1'b0, 1'b1, a, 8'h00);
      @(posedge clock);
      #1 chk("rd_data", exp, rd_data);
      chk("rd_hit", hit, rd_hit);
    end
  endtask
  task conclude;
    begin
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    #20000;
    error_cnt = error_cnt + 1;
    conclude;
  end
  initial
  begin
    repeat (6) @(posedge clock);
    #1 srst = 1'b0;
    for (i = 8; i < 26; i = i + 1)
      rd(i[4:0], 8'h00, 1'b1);
    rd(5'h00, 8'h00, 1'b0);
    rd(5'h1F, 8'h00, 1'b0);
    for (i = 8; i < 26; i = i + 1)
    begin
      sh[i] = 8'h5A ^ (i[7:0] * 8'h07);
      drive(1'b1, 1'b0, i[4:0], sh[i]);
    end
    drive(1'b1, 1'b0, 5'h1A, 8'hFF);
    for (i = 8; i < 26; i = i + 1)
      rd(i[4:0], sh[i], 1'b1);
    chk("freq", {sh[12], sh[11], sh[10], sh[9]}, subcarrier_freq_word);
    chk("phase", sh[13], subcarrier_phase);
    chk("cap_even", {sh[15], sh[14]}, caption_even_bytes);
    chk("cap_odd", {sh[17], sh[16]}, caption_odd_bytes);
    chk("rise", sh[25][7:4], text_request_rise);
    chk("fall", sh[25][3:0], text_request_fall);
    chk("sync", sh[8][3:0], {line_to_field_delay, line_sync_width});
    chk("copy", {sh[22][3:0], sh[23], sh[24]}, copy_generation_data);
    chk("wide", {sh[23][5:0], sh[24]}, wide_screen_data);
    sh[22] = 8'hF9;
    drive(1'b1, 1'b0, 5'h16, sh[22]);
    drive(1'b0, 1'b0, 5'h00, 8'h00);
    cw = {sh[23][5:0], sh[24]};
    crc = 6'h3F;
    for (i = 0; i < 14; i = i + 1)
      crc = {crc[4:0], 1'b0} ^ ((crc[5] ^ cw[i]) ? 6'h03 : 6'h00);
    #1 chk("auto_crc", {crc, cw}, copy_generation_data);
    chk("crc_sel", 1'b1, auto_crc_select);
    for (m = 0; m < 16; m = m + 1)
    begin
      @(posedge clock);
      #1 {pal_mode, master_mode, timing_mode} = m[3:0];
      #1 chk("ped_o", pal_mode ? 16'h0000 : {sh[19], sh[18]}, pedestal_odd_lines);
      chk("ped_e", pal_mode ? 16'h0000 : {sh[21], sh[20]}, pedestal_even_lines);
      chk("txt_o", pal_mode ? {sh[19], sh[18]} : 16'h0000, text_odd_lines);
      chk("txt_e", pal_mode ? {sh[21], sh[20]} : 16'h0000, text_even_lines);
      chk("f_rise", (master_mode && timing_mode == 2'h1) ? sh[8][5:4] : 2'h0, line_to_field_rise_delay);
      chk("f_width", (master_mode && timing_mode == 2'h2) ? sh[8][5:4] : 2'h0, frame_sync_width);
      chk("pix", sh[8][7:6], line_to_pixel_adjust);
      chk("cp_en", {sh[22][6:5] & {2{~pal_mode}}, sh[22][7] & pal_mode},
        {even_field_copy_enable, odd_field_copy_enable, wide_screen_enable});
    end
    drive(1'b1, 1'b0, 5'h19, 8'h70);
    rd(5'h19, 8'h70, 1'b1);
    rise_move = 1'b1;
    #1 chk("track", 1'b1, fall_tracks_rise);
    drive(1'b1, 1'b0, 5'h19, 8'h72);
    drive(1'b0, 1'b0, 5'h00, 8'h00);
    #1 chk("track", 1'b0, fall_tracks_rise);
    rise_move = 1'b0;
    {pal_mode, master_mode, timing_mode} = 4'b0110;
    drive(1'b1, 1'b0, 5'h08, 8'hA5);
    rd(5'h08, 8'hA5, 1'b1);
    chk("f_width", 2'h2, frame_sync_width);
    chk("width", 2'h1, line_sync_width);
    conclude;
  end
endmodule // video_encoder_timing_vbi_regs_test
